// *** inc/sdq_pkg.sv ***
// constants, types and register map of the shear and press dwell sequencer
// Operation
// - the shear-down dwell is 1 to 9999 ms and holds the shear-down output that long on each cut where shear complete does not arrive first.
// - with a zero shear-down dwell on a feed-to-stop line the line is held after a cut until shear complete arrives.
// - with a zero shear-down dwell a missing shear complete for 10 s halts the line and raises the error flag.
// - shear complete arriving during the down stroke drops the shear-down output at once.
// - on a non-stop line with zero dwell the line keeps running up to 10 s for shear complete, then halts with error.
// - a separate shear-up dwell drives the shear-up output after the down stroke ends.
// - in flying-die mode the shear-down dwell also serves as the up time.
// - without reaction time the shear fires only once the die reaches minimum die distance.
// - a reaction time of 0 to 500 ms fires the shear that much before the die is expected at minimum distance.
// - the shear never fires before the die has started its acceleration ramp.
// - the length tolerance check is strobed when the shear-down dwell ends.
// - reaction time is used only with tolerance mode cut-and-stop or warn-only.
// - every press has its own 1 to 9999 ms down dwell timing its down output.
// - an enabled press complete input ends that press's down dwell immediately.
// - in flying-die mode each press's down dwell also serves as its up time.
package sdq_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int  CLK_PERIOD_NS = 25;
  localparam int  TICK_NS       = 1000000;
  localparam int  TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int  TIMEOUT_S     = 10;
  localparam int  TIMEOUT_MS    = TIMEOUT_S * 1000;
  localparam real DWELL_MAX_S   = 9.999;
  localparam real REACT_MAX_S   = 0.5;
  localparam int  DW            = 14;
  localparam logic [15:0] DWELL_MAX_MS = 16'(int'(DWELL_MAX_S * 1000.0));
  localparam logic [15:0] REACT_MAX_MS = 16'(int'(REACT_MAX_S * 1000.0));
  // ****************************************
  // register map and reset values
  // ****************************************
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_SDWN   = 8'h04;
  localparam logic [7:0] OFF_SUP    = 8'h08;
  localparam logic [7:0] OFF_REACT  = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_PCEN   = 8'h14;
  localparam logic [7:0] OFF_MEAS   = 8'h18;
  localparam logic [7:0] OFF_PDWN   = 8'h20;
  localparam logic [7:0] OFF_PUP    = 8'h24;
  localparam int         PSTRIDE    = 8;
  localparam int         CTRL_CLR   = 15;
  localparam logic [DW-1:0] RST_DWELL = 14'h00c8;
  localparam logic [DW-1:0] RST_MEAS  = 14'h3fff;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {SH_IDLE = 3'b000, SH_ARM = 3'b001, SH_DOWN = 3'b010, SH_UP = 3'b011} sdq_shear_e;
  typedef enum logic [1:0] {PR_IDLE = 2'b00, PR_DOWN = 2'b01, PR_UP = 2'b10} sdq_press_e;
  typedef enum logic [1:0] {TOL_CUT_STOP = 2'b00, TOL_WARN = 2'b01, TOL_STOP = 2'b10, TOL_OFF = 2'b11} sdq_tol_e;
  typedef struct packed {
    sdq_tol_e tol;
    logic     nonstop;
    logic     flying;
  } sdq_cfg_s;
endpackage

// *** rtl/sdq_sequencer.sv ***
// shear and press dwell sequencer with register port
module sdq_sequencer #(
  parameter int NPRESS     = 2,
  parameter int TICK_CYC   = sdq_pkg::TICK_CYC,
  parameter int TIMEOUT_MS = sdq_pkg::TIMEOUT_MS
) (
  input  wire logic              CLK,         // system clock 40 MHz
  input  wire logic              RESETN,      // async reset, low
  input  wire logic [7:0]        ADDR,        // register byte address
  input  wire logic [15:0]       WDATA,       // write data
  input  wire logic              WR,          // write strobe
  input  wire logic              RD,          // read strobe
  output logic [15:0]            RDATA,       // read data, cycle after RD
  input  wire logic              CUT_REQ,     // cut request pin
  input  wire logic              SHEAR_DONE,  // shear complete switch
  input  wire logic              DIE_RAMP,    // die accelerating
  input  wire logic              DIE_MIN,     // die at minimum distance
  input  wire logic [NPRESS-1:0] PRESS_FIRE,  // press fire requests
  input  wire logic [NPRESS-1:0] PRESS_DONE,  // press complete switches
  output logic                   SHEAR_DN,    // shear down solenoid
  output logic                   SHEAR_UP,    // shear up solenoid
  output logic [NPRESS-1:0]      PRESS_DN,    // press down solenoids
  output logic [NPRESS-1:0]      PRESS_UP,    // press up solenoids
  output logic                   LINE_HOLD,   // inhibit restart of motion
  output logic                   LINE_HALT,   // line halt request
  output logic                   SHEAR_ERR,   // complete timeout error
  output logic                   TOL_CHECK    // tolerance check strobe
);
  import sdq_pkg::*;

  localparam int IW = 4 + 2 * NPRESS;
  localparam logic [DW-1:0] TO_MS = DW'(TIMEOUT_MS);

  typedef struct packed {
    logic [IW-1:0]                s1;
    logic [IW-1:0]                s2;
    logic [IW-1:0]                s3;
    logic [15:0]                  tcnt;
    logic                         tick;
    sdq_cfg_s                     cfg;
    logic [DW-1:0]                sdwn;
    logic [DW-1:0]                sup;
    logic [8:0]                   react;
    logic [NPRESS-1:0]            pcen;
    logic [NPRESS-1:0][DW-1:0]    pdwn;
    logic [NPRESS-1:0][DW-1:0]    pup;
    sdq_shear_e                   st;
    logic [DW-1:0]                timer;
    logic [DW-1:0]                up_len;
    logic [DW-1:0]                ramp;
    logic [DW-1:0]                meas;
    logic                         meas_run;
    logic                         shear_dn;
    logic                         shear_up;
    logic                         hold;
    logic                         halt;
    logic                         err;
    logic                         tol_chk;
    sdq_press_e [NPRESS-1:0]      pst;
    logic [NPRESS-1:0][DW-1:0]    ptim;
    logic [NPRESS-1:0]            pdn;
    logic [NPRESS-1:0]            pupo;
    logic [15:0]                  rdata;
  } sdq_state_s;

  sdq_state_s        q;
  sdq_state_s        n;
  logic              cut_rise;
  logic              sh_done;
  logic              ramp_l;
  logic              min_l;
  logic              min_rise;
  logic [NPRESS-1:0] prise;
  logic [NPRESS-1:0] pdone;
  logic              react_on;
  logic              early;

  function automatic logic dwell_hit(input logic [DW-1:0] t, input logic [DW-1:0] len);
    return ({1'b0, t} + 15'h0001) >= {1'b0, len};
  endfunction

  function automatic logic [DW-1:0] clamp_ms(input logic [15:0] v, input logic [15:0] mx);
    return (v > mx) ? mx[DW-1:0] : v[DW-1:0];
  endfunction

  // ****************************************
  // synchronised pins
  // ****************************************
  assign cut_rise = q.s2[0] & ~q.s3[0];
  assign sh_done  = q.s2[1];
  assign ramp_l   = q.s2[2];
  assign min_l    = q.s2[3];
  assign min_rise = q.s2[3] & ~q.s3[3];
  assign prise    = q.s2[4 +: NPRESS] & ~q.s3[4 +: NPRESS];
  assign pdone    = q.s2[4 + NPRESS +: NPRESS];

  assign react_on = (q.react != 9'h000) && (q.cfg.tol == TOL_CUT_STOP || q.cfg.tol == TOL_WARN);
  assign early    = react_on && (({1'b0, q.ramp} + {6'h00, q.react}) >= {1'b0, q.meas});

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic              down_end;
    logic              to_hit;
    logic [DW-1:0]     ulen;
    down_end = 1'b0;
    to_hit   = 1'b0;
    ulen     = '0;
    n        = q;
    n.s1     = {PRESS_DONE, PRESS_FIRE, DIE_MIN, DIE_RAMP, SHEAR_DONE, CUT_REQ};
    n.s2     = q.s1;
    n.s3     = q.s2;
    n.tol_chk = 1'b0;
    n.rdata  = 16'h0000;
    n.tick   = (q.tcnt == 16'(TICK_CYC - 1));
    n.tcnt   = n.tick ? 16'h0000 : q.tcnt + 16'h0001;

    if (WR)
    begin
      case (ADDR)
        OFF_CTRL:
        begin
          n.cfg = sdq_cfg_s'(WDATA[3:0]);
          if (WDATA[CTRL_CLR])
          begin
            n.err  = 1'b0;
            n.halt = 1'b0;
          end
        end
        OFF_SDWN:  n.sdwn  = clamp_ms(WDATA, DWELL_MAX_MS);
        OFF_SUP:   n.sup   = clamp_ms(WDATA, DWELL_MAX_MS);
        OFF_REACT: n.react = 9'(clamp_ms(WDATA, REACT_MAX_MS));
        OFF_PCEN:  n.pcen  = WDATA[NPRESS-1:0];
        default:   n.pcen  = q.pcen;
      endcase
      for (int i = 0; i < NPRESS; i++)
      begin
        if (ADDR == 8'(OFF_PDWN + PSTRIDE * i))
          n.pdwn[i] = clamp_ms(WDATA, DWELL_MAX_MS);
        if (ADDR == 8'(OFF_PUP + PSTRIDE * i))
          n.pup[i] = clamp_ms(WDATA, DWELL_MAX_MS);
      end
    end

    if (RD)
    begin
      case (ADDR)
        OFF_CTRL:   n.rdata = {12'h000, q.cfg};
        OFF_SDWN:   n.rdata = {2'b00, q.sdwn};
        OFF_SUP:    n.rdata = {2'b00, q.sup};
        OFF_REACT:  n.rdata = {7'h00, q.react};
        OFF_STATUS: n.rdata = 16'({q.pdn, q.st, q.shear_up, q.shear_dn, q.hold, q.halt, q.err});
        OFF_PCEN:   n.rdata = 16'(q.pcen);
        OFF_MEAS:   n.rdata = {2'b00, q.meas};
        default:    n.rdata = 16'h0000;
      endcase
      for (int i = 0; i < NPRESS; i++)
      begin
        if (ADDR == 8'(OFF_PDWN + PSTRIDE * i))
          n.rdata = {2'b00, q.pdwn[i]};
        if (ADDR == 8'(OFF_PUP + PSTRIDE * i))
          n.rdata = {2'b00, q.pup[i]};
      end
    end

    // learn ramp-start to minimum-distance time, for the next cut
    if (q.meas_run)
    begin
      if (q.tick && ramp_l && q.ramp != RST_MEAS)
        n.ramp = q.ramp + 1'b1;
      if (min_rise)
      begin
        n.meas     = q.ramp;
        n.meas_run = 1'b0;
      end
    end

    case (q.st)
      SH_IDLE:
        if (cut_rise)
        begin
          n.st       = SH_ARM;
          n.ramp     = '0;
          n.meas_run = 1'b1;
          n.hold     = (q.sdwn == '0) && !q.cfg.nonstop;
        end
      SH_ARM:
        // fire only on a moving die
        if (ramp_l && (min_l || early))
        begin
          n.st       = SH_DOWN;
          n.shear_dn = 1'b1;
          n.timer    = '0;
        end
      SH_DOWN:
      begin
        if (sh_done)
          down_end = 1'b1;
        else if (q.tick)
        begin
          n.timer = q.timer + 1'b1;
          if (q.sdwn != '0 && dwell_hit(q.timer, q.sdwn))
            down_end = 1'b1;
          if (q.sdwn == '0 && dwell_hit(q.timer, TO_MS))
          begin
            down_end = 1'b1;
            to_hit   = 1'b1;
          end
        end
        if (down_end)
        begin
          ulen       = q.cfg.flying ? q.sdwn : q.sup;
          n.shear_dn = 1'b0;
          n.tol_chk  = 1'b1;
          n.timer    = '0;
          n.up_len   = ulen;
          n.hold     = 1'b0;
          n.shear_up = (ulen != '0);
          n.st       = (ulen != '0) ? SH_UP : SH_IDLE;
        end
      end
      SH_UP:
        if (q.tick)
        begin
          n.timer = q.timer + 1'b1;
          if (dwell_hit(q.timer, q.up_len))
          begin
            n.shear_up = 1'b0;
            n.st       = SH_IDLE;
          end
        end
      default: n.st = SH_IDLE;
    endcase

    // set beats a clear in the same cycle
    if (to_hit)
    begin
      n.err  = 1'b1;
      n.halt = 1'b1;
    end

    for (int i = 0; i < NPRESS; i++)
    begin
      case (q.pst[i])
        PR_IDLE:
          if (prise[i])
          begin
            n.pst[i]  = PR_DOWN;
            n.pdn[i]  = 1'b1;
            n.ptim[i] = '0;
          end
        PR_DOWN:
          if ((q.pcen[i] && pdone[i]) || (q.tick && dwell_hit(q.ptim[i], q.pdwn[i])))
          begin
            ulen       = q.cfg.flying ? q.pdwn[i] : q.pup[i];
            n.pdn[i]   = 1'b0;
            n.ptim[i]  = '0;
            n.pupo[i]  = (ulen != '0);
            n.pst[i]   = (ulen != '0) ? PR_UP : PR_IDLE;
          end
          else if (q.tick)
            n.ptim[i] = q.ptim[i] + 1'b1;
        PR_UP:
          if (q.tick)
          begin
            n.ptim[i] = q.ptim[i] + 1'b1;
            if (dwell_hit(q.ptim[i], q.cfg.flying ? q.pdwn[i] : q.pup[i]))
            begin
              n.pupo[i] = 1'b0;
              n.pst[i]  = PR_IDLE;
            end
          end
        default: n.pst[i] = PR_IDLE;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // reset clears timers and outputs
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      q      <= '0;
      q.sdwn <= RST_DWELL;
      q.sup  <= RST_DWELL;
      q.pdwn <= {NPRESS{RST_DWELL}};
      q.pup  <= {NPRESS{RST_DWELL}};
      q.meas <= RST_MEAS;
    end
    else
      q <= n;
  end

  assign RDATA     = q.rdata;
  assign SHEAR_DN  = q.shear_dn;
  assign SHEAR_UP  = q.shear_up;
  assign PRESS_DN  = q.pdn;
  assign PRESS_UP  = q.pupo;
  assign LINE_HOLD = q.hold;
  assign LINE_HALT = q.halt;
  assign SHEAR_ERR = q.err;
  assign TOL_CHECK = q.tol_chk;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  a_tick_single: assert property (q.tick |=> !q.tick) else $error("tick wider than one cycle");
  a_done_drop: assert property (q.st == SH_DOWN && sh_done |=> !SHEAR_DN && TOL_CHECK) else $error("shear not dropped");
  a_zero_hold: assert property ($rose(SHEAR_DN) && q.sdwn == '0 && !q.cfg.nonstop |-> LINE_HOLD) else $error("no hold");
  a_timeout_halt: assert property (q.st == SH_DOWN && q.sdwn == '0 && !sh_done && q.tick && q.timer == TO_MS - 1'b1
    |=> LINE_HALT && SHEAR_ERR && !SHEAR_DN) else $error("timeout missed");
  a_nonstop_run: assert property ($rose(SHEAR_DN) && q.cfg.nonstop |-> !LINE_HOLD) else $error("nonstop held");
  a_ramp_first: assert property ($rose(SHEAR_DN) |-> $past(ramp_l)) else $error("shear before ramp");
  a_min_wait: assert property ($rose(SHEAR_DN) && !$past(react_on) |-> $past(min_l)) else $error("fired early");
  a_tol_end: assert property ($fell(SHEAR_DN) |-> TOL_CHECK) else $error("no tolerance strobe");
  a_dwell_end: assert property ($fell(SHEAR_DN) && !$past(sh_done) && $past(q.sdwn) != '0
    |-> $past(q.timer) + 1'b1 >= $past(q.sdwn)) else $error("dwell short");
  a_flying_up: assert property ($rose(SHEAR_UP) && q.cfg.flying |-> q.up_len == q.sdwn) else $error("up time");
  a_press_cut: assert property (q.pst[NPRESS-1] == PR_DOWN && q.pcen[NPRESS-1] && pdone[NPRESS-1]
    |=> !PRESS_DN[NPRESS-1]) else $error("press");

  c_timeout: cover property ($rose(SHEAR_ERR));
  c_react: cover property ($rose(SHEAR_DN) && !$past(min_l));
  c_short: cover property (q.st == SH_DOWN && sh_done && q.sdwn != '0);
  c_press: cover property ($fell(PRESS_DN[0]) ##[1:50] $fell(PRESS_UP[0]));
endmodule

// *** tb/sdq_stroke_model.sv ***
// shear and press solenoids with their stroke-complete switches
module sdq_stroke_model #(
  parameter int NPRESS = 2
) (
  input  wire logic              clk,         // system clock
  input  wire logic              shear_dn,    // shear down solenoid
  input  wire logic [NPRESS-1:0] press_dn,    // press down solenoids
  input  var  int                sh_delay,    // cycles to bottom, 0 never
  input  var  int                pr_delay,    // cycles to bottom, 0 never
  output logic                   shear_done,  // shear complete switch
  output logic [NPRESS-1:0]      press_done   // press complete switches
);
  timeunit 1ns;
  timeprecision 100ps;
  int sh_cnt = 0;
  int pr_cnt [NPRESS];

  initial
  begin
    shear_done = 1'b0;
    press_done = '0;
    foreach (pr_cnt[i]) pr_cnt[i] = 0;
  end

  // switch opens as soon as the solenoid lets go; 0 delay models a dead switch
  always @(posedge clk)
  begin
    sh_cnt <= shear_dn ? sh_cnt + 1 : 0;
    shear_done <= shear_dn && sh_delay != 0 && sh_cnt >= sh_delay;
    for (int i = 0; i < NPRESS; i++)
    begin
      pr_cnt[i] <= press_dn[i] ? pr_cnt[i] + 1 : 0;
      press_done[i] <= press_dn[i] && pr_delay != 0 && pr_cnt[i] >= pr_delay;
    end
  end
endmodule

// *** tb/test_sdq_sequencer.sv ***
// self-checking bench for the shear and press dwell sequencer
module test_sdq_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  import sdq_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  localparam int TK = 4;
  localparam int TO = 20;
  logic        clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        cut_req = 1'b0, die_ramp = 1'b0, die_min = 1'b0, early;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [1:0]  press_fire = 2'h0;
  logic [15:0] rdata;
  logic        shear_done, shear_dn, shear_up, line_hold, line_halt, shear_err, tol_check;
  logic [1:0]  press_done, press_dn, press_up;
  int          sh_delay = 0, pr_delay = 0, n_fail = 0, cmp_count = 0, dn, up, tol, hd;
  wire logic [5:0] outs = {press_up, press_dn, shear_up, shear_dn};

  sdq_sequencer #(.NPRESS(2), .TICK_CYC(TK), .TIMEOUT_MS(TO)) dut (
    .CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .CUT_REQ(cut_req), .SHEAR_DONE(shear_done), .DIE_RAMP(die_ramp), .DIE_MIN(die_min),
    .PRESS_FIRE(press_fire), .PRESS_DONE(press_done), .SHEAR_DN(shear_dn), .SHEAR_UP(shear_up),
    .PRESS_DN(press_dn), .PRESS_UP(press_up), .LINE_HOLD(line_hold), .LINE_HALT(line_halt),
    .SHEAR_ERR(shear_err), .TOL_CHECK(tol_check));

  sdq_stroke_model #(.NPRESS(2)) far (
    .clk(clk), .shear_dn(shear_dn), .press_dn(press_dn), .sh_delay(sh_delay),
    .pr_delay(pr_delay), .shear_done(shear_done), .press_done(press_done));

  initial forever #12.5 clk = ~clk;
  // ****************************************
  // tasks
  // ****************************************
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a value outside its band is reported against the lower bound
  task automatic rng(input int v, input int lo, input int hi);
    chk(16'(v), (v >= lo && v <= hi) ? 16'(v) : 16'(lo));
  endtask

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // lengths in cycles of a down output and of the up output after it
  task automatic run(input int kd, input int ku);
    int n;
    n = 0;
    while (outs[kd] !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    {dn, up, tol, hd} = '0;
    while (outs[kd] === 1'b1 && dn < 9000)
    begin
      hd += line_hold;
      @(posedge clk);
      #1;
      dn++;
      tol += tol_check;
    end
    while (outs[ku] === 1'b1 && up < 9000)
    begin
      @(posedge clk);
      #1;
      up++;
      tol += tol_check;
    end
    if (n == 60 || dn == 9000 || up == 9000)
    begin
      chk(16'h0000, 16'h0001);
      close_out();
    end
  endtask

  // early tells whether the shear fired between ramp start and minimum distance
  task automatic cut(input int gap);
    @(posedge clk);
    cut_req <= 1'b1;
    early = 1'b0;
    repeat (10)
    begin
      @(posedge clk);
      #1;
      early |= shear_dn;
    end
    chk(16'(early), 16'h0000);
    @(posedge clk);
    die_ramp <= 1'b1;
    // a reaction shot may finish inside a long gap, so stop waiting once it fires
    for (int g = 0; g < gap && !early; g++)
    begin
      @(posedge clk);
      #1;
      early |= shear_dn;
    end
    @(posedge clk);
    die_min <= 1'b1;
    run(0, 1);
    @(posedge clk);
    {cut_req, die_ramp, die_min} <= 3'b000;
    repeat (8) @(posedge clk);
  endtask

  task automatic fire(input int i);
    @(posedge clk);
    press_fire[i] <= 1'b1;
    run(2 + i, 4 + i);
    @(posedge clk);
    press_fire[i] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(16'({outs, line_hold, line_halt, shear_err, tol_check}), 16'h0000);
    rreg(OFF_STATUS, 16'h0000);
    rreg(OFF_SDWN, 16'(RST_DWELL));
    rreg(OFF_REACT, 16'h0000);
    rreg(OFF_MEAS, 16'(RST_MEAS));
    rreg(8'(OFF_PUP + PSTRIDE), 16'(RST_DWELL));
    wreg(8'h3c, 16'h1234);
    rreg(8'h3c, 16'h0000);
    wreg(OFF_SDWN, 16'hffff);
    rreg(OFF_SDWN, DWELL_MAX_MS);
    wreg(OFF_REACT, 16'hffff);
    rreg(OFF_REACT, REACT_MAX_MS);
    wreg(OFF_PDWN, 16'h0001);
    rreg(OFF_PDWN, 16'h0001);
    wreg(OFF_REACT, 16'h0000);
    wreg(OFF_SDWN, 16'h0005);
    wreg(OFF_SUP, 16'h0003);
    cut(12);
    chk(16'(early), 16'h0000);
    rng(dn, 4 * TK, 5 * TK + 1);
    rng(up, 2 * TK, 3 * TK + 1);
    chk(16'(tol), 16'h0001);
    wreg(OFF_SDWN, 16'h0064);
    sh_delay = 10;
    cut(12);
    rng(dn, 10, 18);
    wreg(OFF_CTRL, 16'h0001);
    wreg(OFF_SDWN, 16'h0005);
    sh_delay = 0;
    cut(12);
    rng(up, 4 * TK, 5 * TK + 1);
    wreg(OFF_CTRL, 16'h0000);
    wreg(OFF_SDWN, 16'h0000);
    sh_delay = 30;
    cut(12);
    rng(dn, 30, 40);
    chk(16'({hd != 0, line_hold, shear_err}), 16'h0004);
    sh_delay = 0;
    cut(12);
    rng(dn, (TO - 1) * TK, TO * TK + 1);
    chk(16'({line_halt, shear_err}), 16'h0003);
    wreg(OFF_CTRL, 16'h8000);
    @(posedge clk);
    #1;
    chk(16'({line_halt, shear_err}), 16'h0000);
    wreg(OFF_CTRL, 16'h0002);
    cut(12);
    rng(dn, (TO - 1) * TK, TO * TK + 1);
    chk(16'({hd != 0, line_halt, shear_err}), 16'h0003);
    wreg(OFF_CTRL, 16'h8000);
    wreg(OFF_SDWN, 16'h0005);
    wreg(OFF_REACT, 16'h01f4);
    // reaction applies only in the first two tolerance modes
    for (int t = 0; t < 4; t++)
    begin
      wreg(OFF_CTRL, 16'(t << 2));
      cut(40);
      chk(16'(early), 16'(t < 2));
    end
    wreg(OFF_CTRL, 16'h0000);
    wreg(OFF_PDWN, 16'h0004);
    wreg(OFF_PUP, 16'h0002);
    fire(0);
    rng(dn, 3 * TK, 4 * TK + 1);
    rng(up, TK, 2 * TK + 1);
    wreg(OFF_PCEN, 16'h0002);
    wreg(8'(OFF_PDWN + PSTRIDE), 16'h0064);
    pr_delay = 6;
    fire(1);
    rng(dn, 6, 14);
    wreg(OFF_CTRL, 16'h0001);
    fire(0);
    rng(up, 3 * TK, 4 * TK + 1);
    close_out();
  end
endmodule
